// file: design/tandem_connection_monitor_sink.sv
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "tcm_consts.svh"
module tandem_connection_monitor_sink #(
   parameter int unsigned SEC_CYCLES = `ONE_SECOND_CYCLES,
   parameter int unsigned MF_FRAMES = `MF_FRAMES,
   parameter int unsigned RDI_POS = `MF_RDI_POS,
   parameter int unsigned ODI_POS = `MF_ODI_POS,
   parameter int unsigned CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic frame_start,
   input wire logic [7:0] tandem_overhead_byte,
   input wire logic incoming_server_fail,
   input wire logic near_errored_block,
   input wire logic trace_differs,
   input wire logic equipment_defect,
   output logic trail_fail_action,
   output logic trail_degrade_action,
   output tcm_pkg::fault_set_t defects,
   output tcm_pkg::fault_set_t causes
);
   localparam int MF_W = $clog2(MF_FRAMES);
   logic [4:0] control;
   logic [15:0] deg_threshold;
   logic [3:0] deg_persist;
   logic aw_full, w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   tcm_pkg::mf_state_t mf_state;
   logic [11:0] fas_shift;
   logic [MF_W-1:0] mf_pos;
   logic fas_err_run;
   logic [31:0] sec_timer;
   logic [15:0] sec_errs;
   logic [3:0] deg_run;
   logic degrade_state;
   logic [2:0] sec_acc, sec_flags;
   logic [CNT_W-1:0] ebc_acc [3];
   logic [CNT_W-1:0] ebc_rep [3];
   logic [3:0] filt;
   tcm_pkg::fault_set_t next_defects, next_causes;

   wire monitoring_active = control[`CTRL_MON_BIT];
   wire trace_dis = control[`CTRL_TRACE_DIS_BIT];
   // Address decode and selection.
   wire write_go = aw_full & w_full & ~bvalid;
   wire wr_ctrl = write_go & (aw_addr == `OFS_CONTROL);
   wire wr_deg = write_go & (aw_addr == `OFS_DEGRADE);
   wire wr_known = wr_ctrl | wr_deg;
   wire rd_go = arvalid & arready;
   wire [MF_W-1:0] mf_last = MF_W'(MF_FRAMES - 1);
   wire [31:0] deg_word = {12'h000, deg_persist, deg_threshold};
   wire [31:0] ctrl_word = {27'h000_0000, control};
   wire [31:0] defect_word = {25'h000_0000, defects};
   wire [31:0] cause_word = {25'h000_0000, causes};
   wire [31:0] ebc_word [3];
   wire [31:0] sec_word = {29'h0000_0000, sec_flags};
   wire rd_known = (araddr[7:5] == 3'b000) & (araddr[1:0] == 2'b00);
   logic [31:0] rd_mux;
   always_comb begin
      unique case (araddr[4:2])
         3'd0: rd_mux = ctrl_word;
         3'd1: rd_mux = deg_word;
         3'd2: rd_mux = defect_word;
         3'd3: rd_mux = cause_word;
         3'd4: rd_mux = ebc_word[0];
         3'd5: rd_mux = ebc_word[1];
         3'd6: rd_mux = ebc_word[2];
         3'd7: rd_mux = sec_word;
      endcase
   end

   assign awready = ~aw_full;
   assign wready = ~w_full;
   assign arready = ~rvalid;

   // Address and data are held separately, so either may come first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (awvalid & awready) begin
            aw_full <= 1'b1;
            aw_addr <= awaddr;
         end else if (write_go) begin
            aw_full <= 1'b0;
         end
         if (wvalid & wready) begin
            w_full <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end else if (write_go) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `RESP_OKAY;
         rdata <= 32'h0000_0000;
      end else begin
         if (write_go) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         if (rd_go) begin
            rvalid <= 1'b1;
            rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
            rdata <= rd_known ? rd_mux : 32'h0000_0000;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control <= `CTRL_RESET;
         deg_threshold <= `DEG_THR_RESET;
         deg_persist <= `DEG_M_RESET;
      end else begin
         if (wr_ctrl & w_strb[0])
            control <= w_data[4:0];
         if (wr_deg & w_strb[0])
            deg_threshold[7:0] <= w_data[7:0];
         if (wr_deg & w_strb[1])
            deg_threshold[15:8] <= w_data[15:8];
         if (wr_deg & w_strb[2])
            deg_persist <= w_data[`DEG_M_LSB +: 4];
      end
   end

   // Bits 7 and 8 of each frame shift in, oldest first.
   wire [11:0] next_fas = {fas_shift[9:0],
      tandem_overhead_byte[`OVH_BIT7], tandem_overhead_byte[`OVH_BIT8]};
   wire fas_ok = (next_fas == `MF_PATTERN);
   wire mf_wrap = (mf_pos == mf_last);
   wire check_go = frame_start & (mf_state == tcm_pkg::in_multiframe)
      & mf_wrap;
   wire [MF_W-1:0] next_pos = mf_wrap ? '0 : mf_pos + 1'b1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mf_state <= tcm_pkg::out_of_multiframe;
         fas_shift <= 12'h000;
         mf_pos <= '0;
         fas_err_run <= 1'b0;
      end else if (frame_start) begin
         fas_shift <= next_fas;
         unique case (mf_state)
            tcm_pkg::out_of_multiframe: begin
               if (fas_ok) begin
                  mf_state <= tcm_pkg::in_multiframe;
                  mf_pos <= '0;
                  fas_err_run <= 1'b0;
               end
            end
            tcm_pkg::in_multiframe: begin
               mf_pos <= next_pos;
               if (check_go & fas_ok)
                  fas_err_run <= 1'b0;
               else if (check_go & fas_err_run)
                  mf_state <= tcm_pkg::out_of_multiframe;
               else if (check_go)
                  fas_err_run <= 1'b1;
            end
         endcase
      end
   end

   // Persistence filters: unequipped, remote, outgoing, trace.
   wire aligned = (mf_state == tcm_pkg::in_multiframe);
   wire rdi_stb = frame_start & aligned & (next_pos == MF_W'(RDI_POS));
   wire odi_stb = frame_start & aligned & (next_pos == MF_W'(ODI_POS));
   wire [3:0] f_stb = {frame_start, odi_stb, rdi_stb, frame_start};
   wire [3:0] f_val = {trace_differs,
      tandem_overhead_byte[`OVH_BIT7], tandem_overhead_byte[`OVH_BIT8],
      tandem_overhead_byte == 8'h00};
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_filt
         logic [2:0] run;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               run <= 3'd0;
               filt[i] <= 1'b0;
            end else if (f_stb[i]) begin
               if (f_val[i] == filt[i]) begin
                  run <= 3'd0;
               end else if (run == 3'(`PERSIST_COUNT - 1)) begin
                  run <= 3'd0;
                  filt[i] <= f_val[i];
               end else begin
                  run <= run + 3'd1;
               end
            end
         end
      end
   endgenerate

   // One-second timer and near-end degrade judgement.
   wire sec_tick = (sec_timer == SEC_CYCLES - 1);
   wire bad_sec = (sec_errs >= deg_threshold);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_timer <= 32'h0000_0000;
         sec_errs <= 16'h0000;
         deg_run <= 4'h0;
         degrade_state <= 1'b0;
      end else begin
         sec_timer <= sec_tick ? 32'h0000_0000 : sec_timer + 32'd1;
         if (sec_tick)
            sec_errs <= {15'h0000, near_errored_block};
         else if (near_errored_block & (sec_errs != 16'hffff))
            sec_errs <= sec_errs + 16'h0001;
         if (sec_tick & (bad_sec == degrade_state)) begin
            deg_run <= 4'h0;
         end else if (sec_tick & (deg_run + 4'h1 >= deg_persist)) begin
            deg_run <= 4'h0;
            degrade_state <= bad_sec;
         end else if (sec_tick) begin
            deg_run <= deg_run + 4'h1;
         end
      end
   end

   always_comb begin
      next_defects.server_fail = incoming_server_fail;
      next_defects.unequipped = filt[0];
      next_defects.tandem_loss = ~aligned;
      next_defects.trace_mismatch = filt[3] & ~trace_dis
         & ~incoming_server_fail;
      next_defects.degrade = degrade_state;
      next_defects.remote = filt[1];
      next_defects.remote_outgoing = filt[2];
   end

   wire any_mask = defects.unequipped | defects.trace_mismatch
      | defects.tandem_loss;
   always_comb begin
      next_causes.unequipped = monitoring_active & defects.unequipped;
      next_causes.tandem_loss = monitoring_active & ~defects.unequipped
         & defects.tandem_loss;
      next_causes.trace_mismatch = monitoring_active & ~defects.unequipped
         & ~defects.tandem_loss & defects.trace_mismatch;
      next_causes.degrade = monitoring_active & ~defects.trace_mismatch
         & ~defects.tandem_loss & defects.degrade;
      next_causes.server_fail = monitoring_active & defects.server_fail
         & control[`CTRL_SSF_REP_BIT];
      next_causes.remote = monitoring_active & ~any_mask & defects.remote
         & control[`CTRL_RDI_REP_BIT];
      next_causes.remote_outgoing = monitoring_active & ~any_mask
         & defects.remote_outgoing & control[`CTRL_ODI_REP_BIT];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         defects <= '0;
         causes <= '0;
         trail_fail_action <= 1'b0;
         trail_degrade_action <= 1'b0;
      end else begin
         defects <= next_defects;
         causes <= next_causes;
         trail_fail_action <= defects.server_fail | defects.unequipped
            | defects.trace_mismatch | defects.tandem_loss;
         trail_degrade_action <= defects.degrade;
      end
   end

   // Block counts restart at the tick with any event of that cycle,
   // so no block is lost across the second boundary.
   wire [2:0] blk = {frame_start & tandem_overhead_byte[`OVH_OUT_ERR_BIT],
      frame_start & tandem_overhead_byte[`OVH_FAR_ERR_BIT],
      near_errored_block};
   wire [2:0] sec_now = {defects.remote_outgoing, defects.remote,
      trail_fail_action | equipment_defect};
   generate
      for (i = 0; i < 3; i++) begin : g_pm
         assign ebc_word[i] = 32'(ebc_rep[i]);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ebc_acc[i] <= '0;
               ebc_rep[i] <= '0;
               sec_acc[i] <= 1'b0;
               sec_flags[i] <= 1'b0;
            end else if (sec_tick) begin
               ebc_rep[i] <= ebc_acc[i];
               ebc_acc[i] <= CNT_W'(blk[i]);
               sec_flags[i] <= sec_acc[i];
               sec_acc[i] <= sec_now[i];
            end else begin
               if (blk[i] & ~(&ebc_acc[i]))
                  ebc_acc[i] <= ebc_acc[i] + 1'b1;
               sec_acc[i] <= sec_acc[i] | sec_now[i];
            end
         end
      end
   endgenerate

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_loss_on_errors: assert property (
      check_go && !fas_ok && fas_err_run |=> ##1 defects.tandem_loss)
      else $error("tandem loss not raised after two bad words");
   a_loss_clears: assert property (
      frame_start && !aligned && fas_ok |=> ##1 !defects.tandem_loss)
      else $error("tandem loss not cleared on good word");
   a_trace_ssf_mask: assert property (
      incoming_server_fail |=> !defects.trace_mismatch)
      else $error("trace mismatch during server fail");
   a_trace_disable: assert property (
      trace_dis |=> !defects.trace_mismatch)
      else $error("trace mismatch while disabled");
   a_fail_action: assert property (
      incoming_server_fail |=> ##1 trail_fail_action)
      else $error("trail fail missing on server fail");
   a_loss_cause_mask: assert property (
      causes.tandem_loss |-> $past(defects.unequipped) == 1'b0)
      else $error("loss cause with unequipped");
   a_trace_cause_mask: assert property (
      causes.trace_mismatch |-> !$past(defects.tandem_loss)
         && !$past(defects.unequipped))
      else $error("trace cause not masked");
   a_degrade_cause: assert property (
      causes.degrade |-> $past(defects.degrade)
         && !$past(defects.trace_mismatch))
      else $error("degrade cause wrong");
   a_remote_option: assert property (
      causes.remote |-> $past(control[`CTRL_RDI_REP_BIT]))
      else $error("remote cause without option");
   a_mon_off_quiet: assert property (
      !monitoring_active ##1 !$past(monitoring_active) |-> causes == '0)
      else $error("cause while monitoring off");
   a_uneq_rise: assert property (
      $rose(defects.unequipped) |-> $past(frame_start
         && tandem_overhead_byte == 8'h00, 2))
      else $error("unequipped rose without zero byte");
   a_count_latch: assert property (
      sec_tick |=> ebc_rep[0] == $past(ebc_acc[0]))
      else $error("near count not latched at second");

   c_loss: cover property ($rose(defects.tandem_loss));
   c_uneq: cover property ($rose(causes.unequipped));
   c_degrade: cover property ($rose(defects.degrade));
   c_write: cover property (write_go && wr_ctrl);
endmodule // tandem_connection_monitor_sink

// file: design/tcm_consts.svh
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH
// Register byte offsets.
`define OFS_CONTROL 8'h00
`define OFS_DEGRADE 8'h04
`define OFS_DEFECTS 8'h08
`define OFS_CAUSES 8'h0c
`define OFS_NEAR_EBC 8'h10
`define OFS_FAR_EBC 8'h14
`define OFS_OUT_EBC 8'h18
`define OFS_SECONDS 8'h1c
// Control register fields.
`define CTRL_MON_BIT 0
`define CTRL_TRACE_DIS_BIT 1
`define CTRL_SSF_REP_BIT 2
`define CTRL_RDI_REP_BIT 3
`define CTRL_ODI_REP_BIT 4
`define CTRL_RESET 5'h00
// Degrade register fields and reset values.
`define DEG_THR_LSB 0
`define DEG_M_LSB 16
`define DEG_THR_RESET 16'h0100
`define DEG_M_RESET 4'h7
// Overhead byte bit positions (bit 1 is the MSB).
`define OVH_FAR_ERR_BIT 3
`define OVH_OUT_ERR_BIT 2
`define OVH_BIT7 1
`define OVH_BIT8 0
`define MF_PATTERN 12'hffe
`define MF_FRAMES 76
`define MF_RDI_POS 2
`define MF_ODI_POS 3
`define PERSIST_COUNT 5
// Timing.
`define CLK_PERIOD_NS 100
`define ONE_SECOND_MS 1000
`define ONE_SECOND_CYCLES (`ONE_SECOND_MS * 1000000 / `CLK_PERIOD_NS)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: design/tcm_pkg.sv
package tcm_pkg;
   typedef struct packed {
      logic server_fail;
      logic unequipped;
      logic tandem_loss;
      logic trace_mismatch;
      logic degrade;
      logic remote;
      logic remote_outgoing;
   } fault_set_t;
   typedef enum logic {
      out_of_multiframe = 1'b0,
      in_multiframe = 1'b1
   } mf_state_t;
endpackage

// file: dv/frame_source.sv
`timescale 1ns/100ps
module frame_source #(
   parameter int GAP = 4,
   parameter int MF = 16,
   parameter int RDI_AT = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic send_zero,
   input wire logic break_align,
   input wire logic remote_bit,
   input wire logic far_error,
   output logic frame_start,
   output logic [7:0] tandem_overhead_byte
);
   int cyc;
   int frm;
   logic [11:0] pat;
   logic [7:0] b;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cyc <= 0;
         frm <= 0;
         frame_start <= 1'b0;
         tandem_overhead_byte <= 8'h00;
      end else if (cyc != GAP - 1) begin
         cyc <= cyc + 1;
         frame_start <= 1'b0;
         // The byte means nothing between strobes, so it toggles there.
         tandem_overhead_byte <= ~tandem_overhead_byte;
      end else begin
         cyc <= 0;
         frm <= (frm == MF - 1) ? 0 : frm + 1;
         frame_start <= 1'b1;
         b = {4'h5, far_error, far_error, 2'b00};
         pat = 12'hffe << (2 * frm);
         if (frm < 6 && !break_align) begin
            b[1:0] = pat[11:10];
         end
         if (frm == 5 + RDI_AT) begin
            b[0] = remote_bit;
         end
         // The outgoing indication rides one frame after the remote one.
         if (frm == 6 + RDI_AT) begin
            b[1] = remote_bit;
         end
         if (send_zero) begin
            b = 8'h00;
         end
         tandem_overhead_byte <= b;
      end
   end
endmodule // frame_source

// file: dv/test_tandem_connection_monitor_sink.sv
`timescale 1ns/100ps
module test_tandem_connection_monitor_sink;
   localparam int SEC = 200;
   localparam int GAP = 4;
   localparam int MFC = 16 * GAP;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp, rsp;
   logic frame_start, trail_fail_action, trail_degrade_action;
   logic [7:0] tandem_overhead_byte;
   logic incoming_server_fail = 0, near_errored_block = 0;
   logic trace_differs = 0, equipment_defect = 0, send_zero = 0;
   logic break_align = 0, remote_bit = 0, far_error = 0;
   logic [31:0] rd;
   tcm_pkg::fault_set_t defects, causes;
   int err_count = 0, tests_run = 0, cycles = 0;
   always #50 aclk = ~aclk;
   tandem_connection_monitor_sink #(.SEC_CYCLES(SEC), .MF_FRAMES(16))
      tandem_connection_monitor_sink_inst (.*);
   frame_source #(.GAP(GAP), .MF(16)) frame_source_inst (.*);
   task end_of_test;
      $display("errors %0d, checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test;
      end
   end
   task chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh;
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(negedge aclk); ah = awready; wh = wready;
         @(posedge aclk); if (ah) awvalid <= 0; if (wh) wvalid <= 0;
      end while (!(ah && wh) && (awvalid || wvalid));
      do begin
         @(negedge aclk); ah = bvalid;
         @(posedge aclk);
      end while (!ah);
      rsp = bresp; bready <= 0;
   endtask
   task rd_reg(input logic [7:0] a);
      logic h;
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(negedge aclk); h = arready;
         @(posedge aclk);
      end while (!h);
      arvalid <= 0;
      do begin
         @(negedge aclk); h = rvalid;
         @(posedge aclk);
      end while (!h);
      rd = rdata; rsp = rresp; rready <= 0;
   endtask
   task wait_bit(input logic c, input int i, input logic v, input int lim,
         input string msg);
      logic [6:0] s;
      int n;
      n = 0;
      @(negedge aclk); s = c ? causes : defects;
      while (s[i] !== v && n < lim) begin
         @(negedge aclk); s = c ? causes : defects; n++;
      end
      chk(s[i] === v, msg);
      @(posedge aclk);
   endtask
   task t_regs;
      rd_reg(8'h00); chk(rd === 32'h0000_0000, "control reset");
      rd_reg(8'h04); chk(rd === 32'h0007_0100, "degrade reset");
      rd_reg(8'h20); chk(rsp === 2'b10 && rd === 0, "unmapped read");
      wr(8'h08, 32'h0000_0007); chk(rsp === 2'b10, "read-only write");
      wr(8'h00, 32'h0000_0001); rd_reg(8'h00);
      chk(rd === 32'h0000_0001 && rsp === 2'b00, "control write");
   endtask
   task t_align;
      wait_bit(1, 4, 1, 4, "loss cause at start");
      wait_bit(0, 4, 0, 3 * MFC, "alignment found");
      wait_bit(1, 4, 0, 4, "loss cause gone");
      @(negedge aclk); chk(trail_fail_action === 0, "fail clear");
      @(posedge aclk); break_align <= 1;
      repeat (MFC + 2 * GAP) @(posedge aclk);
      wait_bit(0, 4, 0, 0, "one bad word kept");
      wait_bit(0, 4, 1, 2 * MFC, "alignment lost");
      wait_bit(1, 4, 1, 4, "loss cause");
      @(negedge aclk); chk(trail_fail_action === 1, "fail on loss");
      @(posedge aclk); break_align <= 0;
      wait_bit(0, 4, 0, 2 * MFC, "one good word");
   endtask
   task t_uneq;
      send_zero <= 1;
      repeat (3 * GAP) @(posedge aclk);
      wait_bit(0, 5, 0, 0, "not yet unequipped");
      wait_bit(0, 5, 1, 3 * GAP, "unequipped set");
      wait_bit(1, 5, 1, 4, "unequipped cause");
      wait_bit(0, 4, 1, 3 * MFC, "loss under zeros");
      wait_bit(1, 4, 0, 0, "loss cause masked");
      wait_bit(1, 5, 1, 0, "unequipped cause kept");
      send_zero <= 0;
      wait_bit(0, 5, 0, 7 * GAP, "unequipped clear");
      wait_bit(0, 4, 0, 3 * MFC, "realigned");
   endtask
   task t_trace;
      trace_differs <= 1;
      wait_bit(0, 3, 1, SEC, "mismatch set");
      wait_bit(1, 3, 1, 4, "mismatch cause");
      incoming_server_fail <= 1;
      wait_bit(0, 3, 0, 4, "mismatch suppressed");
      wait_bit(1, 6, 0, 4, "server cause off");
      @(negedge aclk); chk(trail_fail_action === 1, "fail on ssf");
      @(posedge aclk); wr(8'h00, 32'h0000_0005);
      wait_bit(1, 6, 1, 4, "server cause on");
      incoming_server_fail <= 0;
      wait_bit(0, 3, 1, SEC, "mismatch back");
      trace_differs <= 0;
      wait_bit(0, 3, 0, SEC, "mismatch cleared");
      trace_differs <= 1;
      wait_bit(0, 3, 1, SEC, "mismatch again");
      wr(8'h00, 32'h0000_0003);
      wait_bit(0, 3, 0, SEC, "mismatch disabled");
      trace_differs <= 0; wr(8'h00, 32'h0000_0001);
   endtask
   task t_remote;
      remote_bit <= 1;
      wait_bit(0, 1, 1, 8 * MFC, "remote set");
      wait_bit(0, 0, 1, 2 * GAP, "outgoing set");
      wait_bit(1, 1, 0, 0, "remote unreported");
      wait_bit(1, 0, 0, 0, "outgoing unreported");
      wr(8'h00, 32'h0000_0009);
      wait_bit(1, 1, 1, 4, "remote cause");
      wait_bit(1, 0, 0, 0, "outgoing needs option");
      wr(8'h00, 32'h0000_0019);
      wait_bit(1, 0, 1, 4, "outgoing cause");
      trace_differs <= 1;
      wait_bit(1, 1, 0, SEC, "remote masked");
      wait_bit(1, 0, 0, 4, "outgoing masked");
      trace_differs <= 0; remote_bit <= 0;
      wr(8'h00, 32'h0000_0000);
      repeat (3) @(posedge aclk);
      @(negedge aclk); chk(causes === 7'h00, "causes off");
      @(posedge aclk); wr(8'h00, 32'h0000_0001);
   endtask
   task t_counts;
      wr(8'h04, 32'h0001_0064);
      near_errored_block <= 1; equipment_defect <= 1; far_error <= 1;
      repeat (3 * SEC) @(posedge aclk);
      @(negedge aclk); chk(trail_degrade_action === 1, "degrade on");
      @(posedge aclk);
      wait_bit(1, 2, 1, 0, "degrade cause");
      rd_reg(8'h10); chk(rd === SEC, "near count");
      rd_reg(8'h14); chk(rd === SEC / GAP, "far count");
      rd_reg(8'h18); chk(rd === SEC / GAP, "outgoing count");
      rd_reg(8'h1c); chk(rd[0] === 1'b1, "near defect second");
      near_errored_block <= 0; equipment_defect <= 0; far_error <= 0;
      wait_bit(0, 2, 0, 3 * SEC, "degrade cleared");
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_regs;
      t_align;
      t_uneq;
      t_trace;
      t_remote;
      t_counts;
      end_of_test;
   end
endmodule // test_tandem_connection_monitor_sink
